/* verilog/adcav_readout.sv */
// Averaging readout for a two-channel 12-bit converter.
// Assumes decoded host commands arrive as one-cycle strobes and the
// converter answers each sample request with one data-valid strobe.
//
// Behaviour
// - Init query answers with status and a true/false initialised flag.
// - Read answer carries status and a result from 0 to 4095.
// - Read names channel 0 or 1; only that channel is converted.
// - Averaging count accepts 1..254, resets to 1, sets samples per read.
// - Zero offset accepts 0..65534, resets to 0, applied to each sample.
// - Sample mask accepts 0..65535, resets to FFFF, applied before offset.
// - Switch delay 0..65534 units of 180ns, resets to 1, Revision A only.
// - Each read starts by clearing the 32-bit accumulator.
// - Channel recorded; on Revision A a change waits the switch delay.
// - Each sample takes a 12-bit converter value into a temporary register.
// - Sample ANDed with mask, written back to the temporary register.
// - Masked sample below offset becomes offset, else offset is subtracted.
// - Corrected sample added into the 32-bit accumulator.
// - Acquire, mask, correct, accumulate repeat for the configured count.
// - After the last sample, accumulator divided by count is returned.
`timescale 1ns/10ps
module adcav_readout
  import adcav_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  input  wire logic          rev_a,
  input  wire logic          converter_init_cmd,
  input  wire logic          init_query_cmd,
  input  wire logic          channel_read_cmd,
  input  wire logic          read_channel,
  input  wire logic          collection_param_cmd,
  input  wire adcav_param_s  param_in,
  output logic               conv_req,
  output logic               conv_channel,
  input  wire logic          conv_valid,
  input  wire logic [11:0]   conv_data,
  output logic               query_valid,
  output logic               query_initialised,
  output logic               read_valid,
  output logic [11:0]        read_result,
  output adcav_status_s      status,
  output logic               param_ack,
  output logic               param_reject,
  output logic [7:0]         avg_count,
  output logic [15:0]        zero_offset,
  output logic [15:0]        sample_mask,
  output logic [15:0]        switch_delay
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  typedef enum logic [2:0] {
    ADCAV_IDLE,
    ADCAV_SETTLE,
    ADCAV_ACQ,
    ADCAV_WAIT,
    ADCAV_DIV,
    ADCAV_DIVWAIT
  } adcav_state_e;

  adcav_state_e state_r;
  adcav_state_e state_nxt;

  logic        init_r;
  logic [7:0]  avg_r;
  logic [15:0] ofs_r;
  logic [15:0] mask_r;
  logic [15:0] dly_r;
  logic        cur_ch_r;
  logic        ch_valid_r;
  logic [31:0] acc_r;
  logic [7:0]  left_r;
  logic [15:0] dly_cnt_r;
  logic [2:0]  unit_cnt_r;
  logic        uerr_r;
  logic        perr_r;
  logic        qv_r;
  logic        rv_r;
  logic [11:0] res_r;
  logic        pack_r;
  logic        prej_r;
  logic        corr_valid;
  logic [15:0] corr_data;
  logic        div_done;
  logic [31:0] div_quo;

  // ****************************************************************
  // Parameter write decode
  // ****************************************************************
  // Range check for each selected setting
  wire [15:0] pval     = param_in.value;
  wire        avg_ok   = (pval >= AVG_MIN) && (pval <= AVG_MAX);
  wire        ofs_ok   = pval <= OFS_MAX;
  wire        dly_ok   = pval <= DLY_MAX;
  wire        p_in_rng = (param_in.sel == ADCAV_P_AVG)  ? avg_ok :
                         (param_in.sel == ADCAV_P_OFS)  ? ofs_ok :
                         (param_in.sel == ADCAV_P_DLY)  ? dly_ok : 1'b1;
  wire        busy     = state_r != ADCAV_IDLE;
  // Settings change only while idle; a write in a read's start cycle gives that read old sample count and delay, new offset, mask, divisor
  wire        p_write  = collection_param_cmd && p_in_rng && !busy;
  wire        p_bad    = collection_param_cmd && !p_write;
  wire        wr_avg   = p_write && (param_in.sel == ADCAV_P_AVG);
  wire        wr_ofs   = p_write && (param_in.sel == ADCAV_P_OFS);
  wire        wr_mask  = p_write && (param_in.sel == ADCAV_P_MASK);
  wire        wr_dly   = p_write && (param_in.sel == ADCAV_P_DLY);

  // ****************************************************************
  // Read control decode
  // ****************************************************************
  // Read accepted only when initialised and idle
  wire        rd_go    = channel_read_cmd && init_r && !busy;
  wire        rd_bad   = channel_read_cmd && !rd_go;
  // Delay needed on Revision A when the channel changes
  wire        ch_diff  = !ch_valid_r || (cur_ch_r != read_channel);
  wire        need_dly = rev_a && ch_diff && (dly_r != 16'h0000);
  wire        unit_end = unit_cnt_r == 3'(SW_UNIT_CYC - 1);
  wire        dly_end  = unit_end && (dly_cnt_r == 16'h0001);
  wire        last_smp = left_r == 8'h01;
  wire [31:0] acc_add  = acc_r + {16'h0000, corr_data};
  // Quotient can exceed 4095 when samples below offset take the offset value, so it is capped at RESULT_MAX
  wire [11:0] res_sat  = (div_quo > {20'h00000, RESULT_MAX}) ? RESULT_MAX
                                                            : div_quo[11:0];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Sequence: settle, then per-sample request and wait, then divide
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ADCAV_IDLE:
        if (rd_go)
          state_nxt = need_dly ? ADCAV_SETTLE : ADCAV_ACQ;
      ADCAV_SETTLE:
        if (dly_end)
          state_nxt = ADCAV_ACQ;
      ADCAV_ACQ:
        state_nxt = ADCAV_WAIT;
      ADCAV_WAIT:
        if (corr_valid)
          state_nxt = last_smp ? ADCAV_DIV : ADCAV_ACQ;
      ADCAV_DIV:
        state_nxt = ADCAV_DIVWAIT;
      ADCAV_DIVWAIT:
        if (div_done)
          state_nxt = ADCAV_IDLE;
      default:
        state_nxt = ADCAV_IDLE;
    endcase
  end

  // ****************************************************************
  // State and settings registers
  // ****************************************************************
  // Power-up defaults, then range-checked writes
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ADCAV_IDLE;
      init_r  <= 1'b0;
      avg_r   <= AVG_RESET[7:0];
      ofs_r   <= OFS_RESET;
      mask_r  <= MASK_RESET;
      dly_r   <= DLY_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      if (converter_init_cmd)
        init_r <= 1'b1;
      if (wr_avg)
        avg_r  <= pval[7:0];
      if (wr_ofs)
        ofs_r  <= pval;
      if (wr_mask)
        mask_r <= pval;
      if (wr_dly)
        dly_r  <= pval;
    end
  end

  // ****************************************************************
  // Channel, settle timer, accumulator
  // ****************************************************************
  // Channel recorded at read start; accumulator cleared there too
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cur_ch_r   <= 1'b0;
      ch_valid_r <= 1'b0;
      acc_r      <= 32'h0000_0000;
      left_r     <= 8'h00;
      dly_cnt_r  <= 16'h0000;
      unit_cnt_r <= 3'h0;
    end
    else if (state_r == ADCAV_IDLE)
    begin
      unit_cnt_r <= 3'h0;
      if (rd_go)
      begin
        cur_ch_r   <= read_channel;
        ch_valid_r <= 1'b1;
        acc_r      <= 32'h0000_0000;
        left_r     <= avg_r;
        dly_cnt_r  <= dly_r;
      end
    end
    else if (state_r == ADCAV_SETTLE)
    begin
      // Each delay unit lasts SW_UNIT_CYC clocks
      unit_cnt_r <= unit_end ? 3'h0 : unit_cnt_r + 3'h1;
      if (unit_end)
        dly_cnt_r <= dly_cnt_r - 16'h0001;
    end
    else if ((state_r == ADCAV_WAIT) && corr_valid)
    begin
      acc_r  <= acc_add;
      left_r <= left_r - 8'h01;
    end
  end

  // ****************************************************************
  // Answers and status flags
  // ****************************************************************
  // One-cycle answer strobes; error flags sticky until next accepted command of the same kind
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      qv_r   <= 1'b0;
      rv_r   <= 1'b0;
      res_r  <= 12'h000;
      uerr_r <= 1'b0;
      perr_r <= 1'b0;
      pack_r <= 1'b0;
      prej_r <= 1'b0;
    end
    else
    begin
      qv_r   <= init_query_cmd;
      rv_r   <= (state_r == ADCAV_DIVWAIT) && div_done;
      if ((state_r == ADCAV_DIVWAIT) && div_done)
        res_r <= res_sat;
      pack_r <= p_write;
      prej_r <= p_bad;
      if (rd_bad)
        uerr_r <= 1'b1;
      else if (rd_go)
        uerr_r <= 1'b0;
      if (p_bad)
        perr_r <= 1'b1;
      else if (p_write)
        perr_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Submodules
  // ****************************************************************
  adcav_sample_proc u_sample_proc (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .raw_valid  (conv_valid && (state_r == ADCAV_WAIT)),
    .raw_data   (conv_data),
    .mask       (mask_r),
    .offset     (ofs_r),
    .corr_valid (corr_valid),
    .corr_data  (corr_data)
  );

  // Mean of the sum over the averaging count
  adcav_divider u_divider (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .start      (state_r == ADCAV_DIV),
    .dividend   (acc_r),
    .divisor    (avg_r),
    .done       (div_done),
    .quotient   (div_quo)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign conv_req           = state_r == ADCAV_ACQ;
  assign conv_channel       = cur_ch_r;
  assign query_valid        = qv_r;
  assign query_initialised  = init_r;
  assign read_valid         = rv_r;
  assign read_result        = res_r;
  assign status.init_ok     = init_r;
  assign status.busy        = busy;
  assign status.uninit_err  = uerr_r;
  assign status.param_err   = perr_r;
  assign param_ack          = pack_r;
  assign param_reject       = prej_r;
  assign avg_count          = avg_r;
  assign zero_offset        = ofs_r;
  assign sample_mask        = mask_r;
  assign switch_delay       = dly_r;

endmodule

/* pkg/adcav_pkg.sv */
// Package for the averaging converter readout block.
// Assumes a single 25 MHz clock domain; shared by all design files.
package adcav_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          SW_UNIT_NS      = 180;
  // Cycles per delay unit, least time so rounded up
  localparam int          SW_UNIT_CYC     = (SW_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Settings: ranges and reset values
  // ****************************************************************
  localparam logic [15:0] AVG_MIN         = 16'h0001;
  localparam logic [15:0] AVG_MAX         = 16'h00FE;
  localparam logic [15:0] AVG_RESET       = 16'h0001;
  localparam logic [15:0] OFS_MAX         = 16'hFFFE;
  localparam logic [15:0] OFS_RESET       = 16'h0000;
  localparam logic [15:0] MASK_RESET      = 16'hFFFF;
  localparam logic [15:0] DLY_MAX         = 16'hFFFE;
  localparam logic [15:0] DLY_RESET       = 16'h0001;
  localparam logic [11:0] RESULT_MAX      = 12'hFFF;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ADCAV_P_AVG,
    ADCAV_P_OFS,
    ADCAV_P_MASK,
    ADCAV_P_DLY
  } adcav_param_e;

  typedef struct packed {
    adcav_param_e sel;
    logic [15:0]  value;
  } adcav_param_s;

  typedef struct packed {
    logic        init_ok;
    logic        busy;
    logic        uninit_err;
    logic        param_err;
  } adcav_status_s;

endpackage

/* verilog/adcav_divider.sv */
// Unsigned restoring divider: 32-bit dividend by 8-bit divisor.
// Assumes divisor non-zero; one quotient bit per clock, 32 clocks.
`timescale 1ns/10ps
module adcav_divider
  import adcav_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [7:0]  divisor,
  output logic             done,
  output logic [31:0]      quotient
);

  // ****************************************************************
  // Iteration state
  // ****************************************************************
  logic [31:0] quo_r;
  logic [8:0]  rem_r;
  logic [7:0]  div_r;
  logic [5:0]  cnt_r;
  logic        run_r;
  logic        done_r;

  // Shift in next dividend bit and trial-subtract
  wire  [8:0]  rem_shift = {rem_r[7:0], quo_r[31]};
  wire         fits      = rem_shift >= {1'b0, div_r};
  wire  [8:0]  rem_sub   = rem_shift - {1'b0, div_r};

  // Restoring division truncates toward zero
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      quo_r  <= 32'h0000_0000;
      rem_r  <= 9'h000;
      div_r  <= 8'h00;
      cnt_r  <= 6'h00;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end
    else if (start)
    begin
      quo_r  <= dividend;
      rem_r  <= 9'h000;
      div_r  <= divisor;
      cnt_r  <= 6'h00;
      run_r  <= 1'b1;
      done_r <= 1'b0;
    end
    else if (run_r)
    begin
      quo_r  <= {quo_r[30:0], fits};
      rem_r  <= fits ? rem_sub : rem_shift;
      cnt_r  <= cnt_r + 6'h01;
      run_r  <= cnt_r != 6'h1F;
      done_r <= cnt_r == 6'h1F;
    end
    else
      done_r <= 1'b0;
  end

  assign done     = done_r;
  assign quotient = quo_r;

endmodule

/* verilog/adcav_sample_proc.sv */
// Per-sample mask and zero-offset correction, registered.
// Assumes raw sample is held valid in the cycle its strobe is high.
`timescale 1ns/10ps
module adcav_sample_proc
  import adcav_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        raw_valid,
  input  wire logic [11:0] raw_data,
  input  wire logic [15:0] mask,
  input  wire logic [15:0] offset,
  output logic             corr_valid,
  output logic [15:0]      corr_data
);

  // ****************************************************************
  // Correction
  // ****************************************************************
  logic [15:0] tmp_r;
  logic        tmp_v_r;
  logic [15:0] corr_r;
  logic        corr_v_r;

  // Temporary register holds the masked sample
  wire  [15:0] masked   = {4'h0, raw_data} & mask;
  // Below offset is replaced by the offset, else offset subtracted
  wire         below    = tmp_r < offset;
  wire  [15:0] adjusted = below ? offset : (tmp_r - offset);

  // Stage 1 captures masked raw sample, stage 2 corrects it
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      tmp_r    <= 16'h0000;
      tmp_v_r  <= 1'b0;
      corr_r   <= 16'h0000;
      corr_v_r <= 1'b0;
    end
    else
    begin
      tmp_v_r  <= raw_valid;
      if (raw_valid)
        tmp_r  <= masked;
      corr_v_r <= tmp_v_r;
      if (tmp_v_r)
        corr_r <= adjusted;
    end
  end

  assign corr_valid = corr_v_r;
  assign corr_data  = corr_r;

endmodule

/* test/adcav_readout_sva.sv */
// Checker for the averaging readout: command answers, settings, read flow.
// Assumes it is bound to adcav_readout and sees only its ports.
`timescale 1ns/10ps
module adcav_readout_sva
  import adcav_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          resetn,
  input wire logic          rev_a,
  input wire logic          converter_init_cmd,
  input wire logic          init_query_cmd,
  input wire logic          channel_read_cmd,
  input wire logic          read_channel,
  input wire logic          collection_param_cmd,
  input wire adcav_param_s  param_in,
  input wire logic          conv_req,
  input wire logic          conv_channel,
  input wire logic          conv_valid,
  input wire logic [11:0]   conv_data,
  input wire logic          query_valid,
  input wire logic          query_initialised,
  input wire logic          read_valid,
  input wire logic [11:0]   read_result,
  input wire adcav_status_s status,
  input wire logic          param_ack,
  input wire logic          param_reject,
  input wire logic [7:0]    avg_count,
  input wire logic [15:0]   zero_offset,
  input wire logic [15:0]   sample_mask,
  input wire logic [15:0]   switch_delay
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // ****************************************************************
  // Qualified commands
  // ****************************************************************
  wire logic good_rd = channel_read_cmd && status.init_ok && !status.busy;
  wire logic pw      = collection_param_cmd && !status.busy;
  wire logic is_avg  = param_in.sel == ADCAV_P_AVG;
  wire logic is_ofs  = param_in.sel == ADCAV_P_OFS;
  wire logic is_mask = param_in.sel == ADCAV_P_MASK;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_query_answer: assert property (init_query_cmd |=> query_valid)
    else $error("query not answered");
  a_param_answer: assert property (collection_param_cmd |=> param_ack != param_reject)
    else $error("parameter write without one answer");
  a_avg_accept: assert property (pw && is_avg && param_in.value >= AVG_MIN &&
    param_in.value <= AVG_MAX |=> param_ack && avg_count == $past(param_in.value[7:0]))
    else $error("legal count not stored");
  a_avg_reject: assert property (pw && is_avg && (param_in.value < AVG_MIN ||
    param_in.value > AVG_MAX) |=> param_reject && $stable(avg_count))
    else $error("illegal count taken");
  a_ofs_reject: assert property (pw && is_ofs && param_in.value > OFS_MAX
    |=> param_reject && $stable(zero_offset))
    else $error("illegal offset taken");
  a_mask_write: assert property (pw && is_mask
    |=> param_ack && sample_mask == $past(param_in.value))
    else $error("mask not stored");
  a_busy_reject: assert property (collection_param_cmd && status.busy |=> param_reject)
    else $error("write taken while busy");
  a_uninit_read: assert property (channel_read_cmd && !status.init_ok
    |=> status.uninit_err && !status.busy)
    else $error("read taken while uninitialised");
  a_read_start: assert property (good_rd
    |=> status.busy && conv_channel == $past(read_channel))
    else $error("read did not start on named channel");
  a_fast_request: assert property (good_rd && !rev_a |=> conv_req)
    else $error("sample not requested at once");
  a_settle_wait: assert property (good_rd && rev_a && read_channel != conv_channel &&
    switch_delay != 16'h0000 |=> !conv_req [*5])
    else $error("switch delay cut short");
  a_result_pulse: assert property (read_valid |=> !read_valid)
    else $error("result strobe too long");

  // Main scenarios reached
  c_read: cover property (good_rd ##1 status.busy);
  c_settle: cover property (good_rd && rev_a);
  c_reject: cover property (param_reject);
endmodule

/* test/adcav_conv_model.sv */
// Behavioural two-channel converter answering sample requests.
// Assumes one request pulse per sample; answer value toggles bit 0 per answer.
`timescale 1ns/10ps
module adcav_conv_model
  import adcav_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        conv_req,
  input  wire logic        conv_channel,
  input  wire logic        slow,
  input  wire logic [11:0] base0,
  input  wire logic [11:0] base1,
  output logic             conv_valid,
  output logic [11:0]      conv_data
);
  logic [2:0] wait_r;
  logic       pend_r;
  logic       par_r;

  // Request, optional stall, one-cycle answer of the named channel only
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      conv_valid <= 1'b0;
      conv_data  <= 12'h000;
      pend_r     <= 1'b0;
      wait_r     <= 3'h0;
      par_r      <= 1'b0;
    end
    else
    begin
      conv_valid <= 1'b0;
      conv_data  <= ~conv_data;      // Data not held outside the answer
      if (conv_req && !pend_r)
      begin
        pend_r <= 1'b1;
        wait_r <= slow ? 3'h4 : 3'h0;
      end
      else if (pend_r && wait_r != 3'h0)
        wait_r <= wait_r - 3'h1;
      else if (pend_r)
      begin
        pend_r     <= 1'b0;
        conv_valid <= 1'b1;
        conv_data  <= (conv_channel ? base1 : base0) ^ {11'h000, par_r};
        par_r      <= ~par_r;
      end
    end
  end
endmodule

/* test/tb_adcav_readout.sv */
// Self-checking bench for the averaging readout.
// Assumes the converter model answers each request; 25 MHz clock.
`timescale 1ns/10ps
module tb_adcav_readout
  import adcav_pkg::*;
;
  typedef struct packed {
    logic [7:0]  avg;
    logic [15:0] ofs;
    logic [15:0] mask;
    logic [15:0] dly;
    logic        ch;
    logic        rev;
    logic        slow;
    logic [11:0] res;
  } adcav_row_s;
  localparam logic [11:0] B0 = 12'hA5C;
  localparam logic [11:0] B1 = 12'h3F1;

  logic clk_sys = 0, resetn = 0, rev_a = 0, slow = 0;
  logic converter_init_cmd = 0, init_query_cmd = 0, channel_read_cmd = 0;
  logic read_channel = 0, collection_param_cmd = 0;
  adcav_param_s param_in = '0;
  wire logic conv_req, conv_channel, conv_valid, query_valid, query_initialised;
  wire logic read_valid, param_ack, param_reject;
  wire logic [11:0] conv_data, read_result;
  wire adcav_status_s status;
  wire logic [7:0] avg_count;
  wire logic [15:0] zero_offset, sample_mask, switch_delay;
  int failures = 0, check_count = 0;
  logic cur_ch = 0;
  // Settings, channel, revision, stall, then expected truncated and capped mean
  adcav_row_s rows [6] = '{
    '{8'h01, 16'h0000, 16'hFFFF, 16'h0001, 1'b0, 1'b0, 1'b0, 12'hA5C},
    '{8'h02, 16'h0000, 16'hFFFF, 16'h0001, 1'b1, 1'b0, 1'b1, 12'h3F0},
    '{8'h03, 16'h0010, 16'h0FF0, 16'h0002, 1'b0, 1'b1, 1'b0, 12'hA40},
    '{8'hFE, 16'h0005, 16'hFFFF, 16'h0001, 1'b1, 1'b0, 1'b0, 12'h3EB},
    '{8'h05, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b1, 1'b0, 12'h000},
    '{8'h04, 16'h2000, 16'hFFFF, 16'h0001, 1'b0, 1'b0, 1'b1, 12'hFFF}};
  adcav_param_e rej_sel [4] = '{ADCAV_P_AVG, ADCAV_P_AVG, ADCAV_P_OFS, ADCAV_P_DLY};
  logic [15:0] rej_val [4] = '{16'h0000, 16'h00FF, 16'hFFFF, 16'hFFFF};

  adcav_readout i_dut (.clk_sys(clk_sys), .resetn(resetn), .rev_a(rev_a),
    .converter_init_cmd(converter_init_cmd), .init_query_cmd(init_query_cmd),
    .channel_read_cmd(channel_read_cmd), .read_channel(read_channel),
    .collection_param_cmd(collection_param_cmd), .param_in(param_in),
    .conv_req(conv_req), .conv_channel(conv_channel), .conv_valid(conv_valid),
    .conv_data(conv_data), .query_valid(query_valid),
    .query_initialised(query_initialised), .read_valid(read_valid),
    .read_result(read_result), .status(status), .param_ack(param_ack),
    .param_reject(param_reject), .avg_count(avg_count), .zero_offset(zero_offset),
    .sample_mask(sample_mask), .switch_delay(switch_delay));

  adcav_conv_model i_conv (.clk_sys(clk_sys), .resetn(resetn), .conv_req(conv_req),
    .conv_channel(conv_channel), .slow(slow), .base0(B0), .base1(B1),
    .conv_valid(conv_valid), .conv_data(conv_data));

  // ****************************************************************
  // Clock and helpers
  // ****************************************************************
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task summarize;
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task set_param(input adcav_param_e s, input logic [15:0] v, input logic ok);
    @(posedge clk_sys);
    collection_param_cmd <= 1'b1;
    param_in <= '{sel: s, value: v};
    @(posedge clk_sys);
    collection_param_cmd <= 1'b0;
    #1;
    check(param_ack, ok);
    check(param_reject, !ok);
  endtask

  task query(input logic exp);
    @(posedge clk_sys);
    init_query_cmd <= 1'b1;
    @(posedge clk_sys);
    init_query_cmd <= 1'b0;
    #1;
    check(query_valid, 1'b1);
    check(query_initialised, exp);
  endtask

  task start_read(input logic ch);
    @(posedge clk_sys);
    channel_read_cmd <= 1'b1;
    read_channel <= ch;
    @(posedge clk_sys);
    channel_read_cmd <= 1'b0;
  endtask

  // Waits for the result; gap 0 skips the first-request timing check
  task wait_read(input logic [11:0] exp, input int gap);
    int i;
    int req_at;
    req_at = 0;
    for (i = 1; i < 20000; i++)
    begin
      #1;
      if (conv_req === 1'b1 && req_at == 0)
        req_at = i;
      if (read_valid === 1'b1)
        break;
      @(posedge clk_sys);
    end
    if (i == 20000)
    begin
      failures++;
      summarize();
    end
    check(read_result, exp);
    if (gap == 1)
      check(req_at, 1);
    else if (gap > 1)
      check(req_at, gap);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1;
    check(avg_count, 8'h01);
    check(zero_offset, OFS_RESET);
    check(sample_mask, MASK_RESET);
    check(switch_delay, DLY_RESET);
    query(1'b0);
    start_read(1'b1);
    #1;
    check(status.uninit_err, 1'b1);
    check(conv_req, 1'b0);
    @(posedge clk_sys);
    converter_init_cmd <= 1'b1;
    @(posedge clk_sys);
    converter_init_cmd <= 1'b0;
    query(1'b1);
    for (int i = 0; i < 4; i++)
      set_param(rej_sel[i], rej_val[i], 1'b0);
    check({avg_count, switch_delay, status}, {8'h01, 16'h0001, 4'hB});
    foreach (rows[i])
    begin
      set_param(ADCAV_P_AVG, {8'h00, rows[i].avg}, 1'b1);
      set_param(ADCAV_P_OFS, rows[i].ofs, 1'b1);
      set_param(ADCAV_P_MASK, rows[i].mask, 1'b1);
      set_param(ADCAV_P_DLY, rows[i].dly, 1'b1);
      check(switch_delay, rows[i].dly);
      rev_a <= rows[i].rev;
      slow <= rows[i].slow;
      start_read(rows[i].ch);
      wait_read(rows[i].res, (rows[i].rev && rows[i].ch != cur_ch &&
        rows[i].dly != 16'h0) ? rows[i].dly * SW_UNIT_CYC + 1 : 1);
      check(conv_channel, rows[i].ch);
      cur_ch = rows[i].ch;
    end
    start_read(1'b0);
    set_param(ADCAV_P_AVG, 16'h0002, 1'b0);
    start_read(1'b1);
    #1;
    check({status.busy, status.uninit_err, conv_channel}, 3'h6);
    wait_read(rows[5].res, 0);
    @(posedge clk_sys);
    resetn <= 1'b0;
    @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1;
    check({avg_count, query_initialised}, {8'h01, 1'b0});
    summarize();
  end
endmodule

bind adcav_readout adcav_readout_sva i_sva (.clk_sys(clk_sys), .resetn(resetn),
  .rev_a(rev_a), .converter_init_cmd(converter_init_cmd), .init_query_cmd(init_query_cmd),
  .channel_read_cmd(channel_read_cmd), .read_channel(read_channel),
  .collection_param_cmd(collection_param_cmd), .param_in(param_in), .conv_req(conv_req),
  .conv_channel(conv_channel), .conv_valid(conv_valid), .conv_data(conv_data),
  .query_valid(query_valid), .query_initialised(query_initialised),
  .read_valid(read_valid), .read_result(read_result), .status(status),
  .param_ack(param_ack), .param_reject(param_reject), .avg_count(avg_count),
  .zero_offset(zero_offset), .sample_mask(sample_mask), .switch_delay(switch_delay));
